// >>> verilog/cpu_alu_consts.vh
// constants for the alu and flow control block
// assumes a 32-bit ahb-lite register bus, word access only
`ifndef CPU_ALU_CONSTS_VH
`define CPU_ALU_CONSTS_VH
// register byte offsets
`define OFS_CMD 8'h00
`define OFS_OPD 8'h04
`define OFS_OPR 8'h08
`define OFS_WORD 8'h0C
`define OFS_KARG 8'h10
`define OFS_ZPTR 8'h14
`define OFS_SREG 8'h18
`define OFS_PC 8'h1C
`define OFS_PROD 8'h20
`define OFS_STAT 8'h24
// command register fields
`define CMD_OPC_HI 5
`define CMD_OPC_LO 0
`define CMD_BIT_HI 10
`define CMD_BIT_LO 8
`define CMD_TWO_WORD 12
// status flag positions
`define SF_C 0
`define SF_Z 1
`define SF_N 2
`define SF_V 3
`define SF_S 4
`define SF_H 5
`define SF_I 7
// reset values
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_SREG 8'h00
// cycle counts
`define CYC_ALU 3'h1
`define CYC_WORD 3'h2
`define CYC_MUL 3'h2
`define CYC_JUMP_SHORT 3'h2
`define CYC_JUMP_ABS 3'h3
`define CYC_CALL_SHORT 3'h3
`define CYC_CALL_ABS 3'h4
`define CYC_RET 3'h4
`define CYC_SKIP_ONE 3'h2
`define CYC_SKIP_TWO 3'h3
// alu operations
`define ALU_ADD 3'h0
`define ALU_SUB 3'h1
`define ALU_AND 3'h2
`define ALU_OR 3'h3
`define ALU_XOR 3'h4
// opcodes
`define OP_ADD 6'h00
`define OP_ADD_CARRY 6'h01
`define OP_ADD_IMM_WORD 6'h02
`define OP_SUB 6'h03
`define OP_SUB_IMM 6'h04
`define OP_SUB_WITH_CARRY 6'h05
`define OP_SUB_IMM_WITH_CARRY 6'h06
`define OP_SUB_IMM_WORD 6'h07
`define OP_AND 6'h08
`define OP_AND_IMM 6'h09
`define OP_OR 6'h0A
`define OP_OR_IMM 6'h0B
`define OP_XOR_REGS 6'h0C
`define OP_SET_BITS 6'h0D
`define OP_CLEAR_BITS 6'h0E
`define OP_TEST_ZERO_MINUS 6'h0F
`define OP_CLEAR_REG 6'h10
`define OP_SET_ALL_ONES 6'h11
`define OP_MULT_UNSIGNED 6'h12
`define OP_MULT_SIGNED 6'h13
`define OP_MULT_MIXED 6'h14
`define OP_FRAC_MULT_UNSIGNED 6'h15
`define OP_FRAC_MULT_SIGNED 6'h16
`define OP_FRAC_MULT_MIXED 6'h17
`define OP_REL_JUMP 6'h18
`define OP_IND_JUMP 6'h19
`define OP_ABS_JUMP 6'h1A
`define OP_REL_CALL 6'h1B
`define OP_IND_CALL 6'h1C
`define OP_ABS_CALL 6'h1D
`define OP_SUB_RETURN 6'h1E
`define OP_IRQ_RETURN 6'h1F
`define OP_COMPARE_SKIP_EQUAL 6'h20
`define OP_COMPARE 6'h21
`define OP_COMPARE_WITH_CARRY 6'h22
`define OP_COMPARE_IMM 6'h23
`define OP_SKIP_REG_BIT_CLEAR 6'h24
`define OP_SKIP_REG_BIT_SET 6'h25
`define OP_SKIP_IO_BIT_CLEAR 6'h26
`define OP_SKIP_IO_BIT_SET 6'h27
`endif

// >>> verilog/alu8.v
// 8-bit adder, subtractor and logic unit with flags
// assumes operands and carry are prepared by the caller
`default_nettype none
`include "cpu_alu_consts.vh"
module alu8 (
	input wire [7:0] a,
	input wire [7:0] b,
	input wire cin,
	input wire [2:0] op,
	input wire chainZ,
	input wire zIn,
	output reg [7:0] res,
	output reg hf,
	output reg vf,
	output reg cf,
	output wire nf,
	output wire zf
);
	assign nf = res[7];
	// chained subtract keeps a previous zero
	assign zf = (res == 8'h00) & (~chainZ | zIn);
	always @* begin
		res = a;
		hf = 1'b0;
		vf = 1'b0;
		cf = 1'b0;
		case (op)
		`ALU_ADD: begin
			res = a + b + {7'h00, cin};
			hf = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
			vf = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
			cf = (a[7] & b[7]) | (b[7] & ~res[7]) | (~res[7] & a[7]);
		end
		`ALU_SUB: begin
			res = a - b - {7'h00, cin};
			hf = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
			vf = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
			cf = (~a[7] & b[7]) | (b[7] & res[7]) | (res[7] & ~a[7]);
		end
		`ALU_AND: res = a & b;
		`ALU_OR: res = a | b;
		`ALU_XOR: res = a ^ b;
		default: res = a;
		endcase
	end
endmodule // alu8
`default_nettype wire

// >>> verilog/mult8.v
// 8x8 multiplier, signed, unsigned or mixed, with fractional shift
// assumes the caller picks signedness per operand
`default_nettype none
module mult8 (
	input wire [7:0] a,
	input wire [7:0] b,
	input wire aSigned,
	input wire bSigned,
	input wire frac,
	output wire [15:0] prod,
	output wire zf,
	output wire cf
);
	wire [15:0] ea;
	wire [15:0] eb;
	wire [31:0] full;
	wire [15:0] raw;
	assign ea = {{8{aSigned & a[7]}}, a};
	assign eb = {{8{bSigned & b[7]}}, b};
	assign full = ea * eb;
	assign raw = full[15:0];
	// carry is the top bit before any shift
	assign cf = raw[15];
	assign prod = frac ? {raw[14:0], 1'b0} : raw;
	assign zf = (prod == 16'h0000);
endmodule // mult8
`default_nettype wire

// >>> verilog/cpu_alu_flow.v
// alu and flow control execution unit behind an ahb-lite slave
// assumes a single master, word transfers, one clock mclk
//
// What this block does
// - add two registers, optional carry, flags Z C N V H, one cycle
// - subtract register or constant, optional carry, flags Z C N V H
// - add constant to register pair, flags Z C N V S, two cycles
// - subtract constant from register pair, flags Z C N V S, two cycles
// - and, or with register or constant, xor with register, flags Z N V, one cycle
// - set bits ors a mask, clear bits ands its complement, Z N V
// - test ands with itself, clear xors itself, set loads all ones
// - multiply unsigned, signed or mixed into product pair, flags Z C
// - fractional multiplies shift the product left one, flags Z C
// - relative jump pc+k+1, indirect from Z, two cycles; absolute three
// - short calls three cycles, direct four; returns pop pc in four
// - compare registers, skip next instruction when equal
// - compares subtract without storing, flags Z N V C H
// - register bit skips on clear or on set
// - io bit skips on its bit, flags untouched
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`default_nettype none
`include "cpu_alu_consts.vh"
module cpu_alu_flow #(
	parameter SP_W = 3
) (
	input wire mclk,
	input wire reset,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	output wire busy
);
	localparam ST_IDLE = 2'b01;
	localparam ST_EXEC = 2'b10;
	localparam DEPTH = 1 << SP_W;

	reg [1:0] state_r;
	reg [2:0] cnt_r;
	reg [5:0] opc_r;
	reg [2:0] bitSel_r;
	reg twoWord_r;
	reg [7:0] opD_r;
	reg [7:0] opR_r;
	reg [15:0] word_r;
	reg [15:0] kArg_r;
	reg [15:0] zPtr_r;
	reg [7:0] sreg_r;
	reg [15:0] pc_r;
	reg [15:0] prod_r;
	reg skipTaken_r;
	reg [SP_W-1:0] sp_r;
	reg [15:0] stack_r [0:DEPTH-1];
	reg wrPend_r;
	reg rdPend_r;
	reg [7:0] addr_r;

	// bus address phase
	wire accept;
	wire cmdWrite;
	assign accept = hsel & hready & htrans[1];
	assign hreadyout = ~rdPend_r;
	assign hresp = 1'b0;
	assign busy = state_r[1];
	assign cmdWrite = wrPend_r & (addr_r == `OFS_CMD) & state_r[0];

	// alu operand steering
	reg [2:0] aluOp;
	reg [7:0] aluB;
	reg aluCin;
	reg aluChain;
	wire [7:0] aluRes;
	wire aluH;
	wire aluV;
	wire aluC;
	wire aluN;
	wire aluZ;
	always @* begin
		aluOp = `ALU_ADD;
		aluB = opR_r;
		aluCin = 1'b0;
		aluChain = 1'b0;
		case (opc_r)
		`OP_ADD_CARRY: aluCin = sreg_r[`SF_C];
		`OP_SUB, `OP_SUB_IMM, `OP_COMPARE, `OP_COMPARE_IMM:
			aluOp = `ALU_SUB;
		`OP_SUB_WITH_CARRY, `OP_SUB_IMM_WITH_CARRY,
		`OP_COMPARE_WITH_CARRY: begin
			aluOp = `ALU_SUB;
			aluCin = sreg_r[`SF_C];
			aluChain = 1'b1;
		end
		`OP_AND, `OP_AND_IMM: aluOp = `ALU_AND;
		`OP_OR, `OP_OR_IMM, `OP_SET_BITS: aluOp = `ALU_OR;
		`OP_XOR_REGS: aluOp = `ALU_XOR;
		`OP_CLEAR_BITS: begin
			aluOp = `ALU_AND;
			aluB = ~opR_r;
		end
		`OP_TEST_ZERO_MINUS: begin
			aluOp = `ALU_AND;
			aluB = opD_r;
		end
		`OP_CLEAR_REG: begin
			aluOp = `ALU_XOR;
			aluB = opD_r;
		end
		default: aluOp = `ALU_ADD;
		endcase
	end

	alu8 u_alu (
		.a(opD_r),
		.b(aluB),
		.cin(aluCin),
		.op(aluOp),
		.chainZ(aluChain),
		.zIn(sreg_r[`SF_Z]),
		.res(aluRes),
		.hf(aluH),
		.vf(aluV),
		.cf(aluC),
		.nf(aluN),
		.zf(aluZ)
	);

	// multiplier operand signedness
	wire mulASigned;
	wire mulBSigned;
	wire mulFrac;
	wire [15:0] mulProd;
	wire mulZ;
	wire mulC;
	assign mulASigned = (opc_r == `OP_MULT_SIGNED) |
		(opc_r == `OP_MULT_MIXED) | (opc_r == `OP_FRAC_MULT_SIGNED) |
		(opc_r == `OP_FRAC_MULT_MIXED);
	assign mulBSigned = (opc_r == `OP_MULT_SIGNED) |
		(opc_r == `OP_FRAC_MULT_SIGNED);
	assign mulFrac = (opc_r == `OP_FRAC_MULT_UNSIGNED) |
		(opc_r == `OP_FRAC_MULT_SIGNED) |
		(opc_r == `OP_FRAC_MULT_MIXED);

	mult8 u_mult (
		.a(opD_r),
		.b(opR_r),
		.aSigned(mulASigned),
		.bSigned(mulBSigned),
		.frac(mulFrac),
		.prod(mulProd),
		.zf(mulZ),
		.cf(mulC)
	);

	// word arithmetic
	wire [15:0] wordAdd;
	wire [15:0] wordSub;
	assign wordAdd = word_r + {8'h00, opR_r};
	assign wordSub = word_r - {8'h00, opR_r};

	// stack top
	wire [SP_W-1:0] spDec;
	wire [15:0] popVal;
	assign spDec = sp_r - {{(SP_W-1){1'b0}}, 1'b1};
	assign popVal = stack_r[spDec];

	// execution results
	reg [7:0] opD_nxt;
	reg [15:0] word_nxt;
	reg [7:0] sreg_nxt;
	reg [15:0] pc_nxt;
	reg [15:0] prod_nxt;
	reg [2:0] cyc_nxt;
	reg push;
	reg [15:0] pushVal;
	reg pop;
	reg skipCond;
	reg isSkip;
	reg vW;
	always @* begin
		opD_nxt = opD_r;
		word_nxt = word_r;
		sreg_nxt = sreg_r;
		pc_nxt = pc_r + 16'h0001;
		prod_nxt = prod_r;
		cyc_nxt = `CYC_ALU;
		push = 1'b0;
		pushVal = pc_r + 16'h0001;
		pop = 1'b0;
		skipCond = 1'b0;
		isSkip = 1'b0;
		vW = 1'b0;
		case (opc_r)
		`OP_ADD, `OP_ADD_CARRY, `OP_SUB, `OP_SUB_IMM,
		`OP_SUB_WITH_CARRY, `OP_SUB_IMM_WITH_CARRY: begin
			opD_nxt = aluRes;
			sreg_nxt = {sreg_r[7:6], aluH, sreg_r[4], aluV, aluN, aluZ, aluC};
		end
		`OP_COMPARE, `OP_COMPARE_WITH_CARRY, `OP_COMPARE_IMM:
			sreg_nxt = {sreg_r[7:6], aluH, sreg_r[4], aluV, aluN, aluZ, aluC};
		`OP_AND, `OP_AND_IMM, `OP_OR, `OP_OR_IMM, `OP_XOR_REGS,
		`OP_SET_BITS, `OP_CLEAR_BITS, `OP_CLEAR_REG: begin
			opD_nxt = aluRes;
			sreg_nxt = {sreg_r[7:4], 1'b0, aluN, aluZ, sreg_r[0]};
		end
		`OP_TEST_ZERO_MINUS:
			sreg_nxt = {sreg_r[7:4], 1'b0, aluN, aluZ, sreg_r[0]};
		`OP_SET_ALL_ONES: opD_nxt = 8'hFF;
		`OP_ADD_IMM_WORD: begin
			word_nxt = wordAdd;
			vW = ~word_r[15] & wordAdd[15];
			sreg_nxt = {sreg_r[7:5], wordAdd[15] ^ vW, vW, wordAdd[15],
				wordAdd == 16'h0000, word_r[15] & ~wordAdd[15]};
			cyc_nxt = `CYC_WORD;
		end
		`OP_SUB_IMM_WORD: begin
			word_nxt = wordSub;
			vW = word_r[15] & ~wordSub[15];
			sreg_nxt = {sreg_r[7:5], wordSub[15] ^ vW, vW, wordSub[15],
				wordSub == 16'h0000, wordSub[15] & ~word_r[15]};
			cyc_nxt = `CYC_WORD;
		end
		`OP_MULT_UNSIGNED, `OP_MULT_SIGNED, `OP_MULT_MIXED,
		`OP_FRAC_MULT_UNSIGNED, `OP_FRAC_MULT_SIGNED,
		`OP_FRAC_MULT_MIXED: begin
			prod_nxt = mulProd;
			sreg_nxt = {sreg_r[7:2], mulZ, mulC};
			cyc_nxt = `CYC_MUL;
		end
		`OP_REL_JUMP: begin
			pc_nxt = pc_r + kArg_r + 16'h0001;
			cyc_nxt = `CYC_JUMP_SHORT;
		end
		`OP_IND_JUMP: begin
			pc_nxt = zPtr_r;
			cyc_nxt = `CYC_JUMP_SHORT;
		end
		`OP_ABS_JUMP: begin
			pc_nxt = kArg_r;
			cyc_nxt = `CYC_JUMP_ABS;
		end
		`OP_REL_CALL: begin
			push = 1'b1;
			pc_nxt = pc_r + kArg_r + 16'h0001;
			cyc_nxt = `CYC_CALL_SHORT;
		end
		`OP_IND_CALL: begin
			push = 1'b1;
			pc_nxt = zPtr_r;
			cyc_nxt = `CYC_CALL_SHORT;
		end
		`OP_ABS_CALL: begin
			push = 1'b1;
			pushVal = pc_r + 16'h0002;
			pc_nxt = kArg_r;
			cyc_nxt = `CYC_CALL_ABS;
		end
		`OP_SUB_RETURN: begin
			pop = 1'b1;
			pc_nxt = popVal;
			cyc_nxt = `CYC_RET;
		end
		`OP_IRQ_RETURN: begin
			pop = 1'b1;
			pc_nxt = popVal;
			sreg_nxt[`SF_I] = 1'b1;
			cyc_nxt = `CYC_RET;
		end
		`OP_COMPARE_SKIP_EQUAL: begin
			isSkip = 1'b1;
			skipCond = (opD_r == opR_r);
		end
		`OP_SKIP_REG_BIT_CLEAR: begin
			isSkip = 1'b1;
			skipCond = ~opD_r[bitSel_r];
		end
		`OP_SKIP_REG_BIT_SET: begin
			isSkip = 1'b1;
			skipCond = opD_r[bitSel_r];
		end
		`OP_SKIP_IO_BIT_CLEAR: begin
			isSkip = 1'b1;
			skipCond = ~opR_r[bitSel_r];
		end
		`OP_SKIP_IO_BIT_SET: begin
			isSkip = 1'b1;
			skipCond = opR_r[bitSel_r];
		end
		default: cyc_nxt = `CYC_ALU;
		endcase
		if (isSkip & skipCond) begin
			pc_nxt = pc_r + (twoWord_r ? 16'h0003 : 16'h0002);
			cyc_nxt = twoWord_r ? `CYC_SKIP_TWO : `CYC_SKIP_ONE;
		end
	end

	// read mux
	reg [31:0] rdMux;
	always @* begin
		case (addr_r)
		`OFS_CMD: rdMux = {19'h0_0000, twoWord_r, 1'b0, bitSel_r,
			2'b00, opc_r};
		`OFS_OPD: rdMux = {24'h00_0000, opD_r};
		`OFS_OPR: rdMux = {24'h00_0000, opR_r};
		`OFS_WORD: rdMux = {16'h0000, word_r};
		`OFS_KARG: rdMux = {16'h0000, kArg_r};
		`OFS_ZPTR: rdMux = {16'h0000, zPtr_r};
		`OFS_SREG: rdMux = {24'h00_0000, sreg_r};
		`OFS_PC: rdMux = {16'h0000, pc_r};
		`OFS_PROD: rdMux = {16'h0000, prod_r};
		`OFS_STAT: rdMux = {{(24-SP_W){1'b0}}, sp_r, 6'h00, skipTaken_r,
			busy};
		default: rdMux = 32'h0000_0000;
		endcase
	end

	// bus phases and read data
	always @(posedge mclk) begin
		if (reset) begin
			wrPend_r <= 1'b0;
			rdPend_r <= 1'b0;
			addr_r <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else begin
			if (rdPend_r)
				hrdata <= rdMux;
			if (accept) begin
				wrPend_r <= hwrite;
				rdPend_r <= ~hwrite;
				addr_r <= {haddr[7:2], 2'b00};
			end else begin
				wrPend_r <= 1'b0;
				rdPend_r <= 1'b0;
			end
		end
	end

	// register writes and execution
	always @(posedge mclk) begin
		if (reset) begin
			state_r <= ST_IDLE;
			cnt_r <= 3'h0;
			opc_r <= 6'h00;
			bitSel_r <= 3'h0;
			twoWord_r <= 1'b0;
			opD_r <= `RST_BYTE;
			opR_r <= `RST_BYTE;
			word_r <= `RST_WORD;
			kArg_r <= `RST_WORD;
			zPtr_r <= `RST_WORD;
			sreg_r <= `RST_SREG;
			pc_r <= `RST_WORD;
			prod_r <= `RST_WORD;
			skipTaken_r <= 1'b0;
			sp_r <= {SP_W{1'b0}};
		end else begin
			case (state_r)
			ST_IDLE: begin
				if (cmdWrite) begin
					opc_r <= hwdata[`CMD_OPC_HI:`CMD_OPC_LO];
					bitSel_r <= hwdata[`CMD_BIT_HI:`CMD_BIT_LO];
					twoWord_r <= hwdata[`CMD_TWO_WORD];
					state_r <= ST_EXEC;
				end else if (wrPend_r) begin
					case (addr_r)
					`OFS_OPD: opD_r <= hwdata[7:0];
					`OFS_OPR: opR_r <= hwdata[7:0];
					`OFS_WORD: word_r <= hwdata[15:0];
					`OFS_KARG: kArg_r <= hwdata[15:0];
					`OFS_ZPTR: zPtr_r <= hwdata[15:0];
					`OFS_SREG: sreg_r <= hwdata[7:0];
					`OFS_PC: pc_r <= hwdata[15:0];
					default: sreg_r <= sreg_r;
					endcase
				end
			end
			ST_EXEC: begin
				// first exec cycle commits, then counts out the rest
				if (cnt_r == 3'h0) begin
					opD_r <= opD_nxt;
					word_r <= word_nxt;
					sreg_r <= sreg_nxt;
					pc_r <= pc_nxt;
					prod_r <= prod_nxt;
					skipTaken_r <= isSkip & skipCond;
					if (push) begin
						stack_r[sp_r] <= pushVal;
						sp_r <= sp_r + {{(SP_W-1){1'b0}}, 1'b1};
					end else if (pop)
						sp_r <= spDec;
					if (cyc_nxt == 3'h1)
						state_r <= ST_IDLE;
					else
						cnt_r <= cyc_nxt - 3'h1;
				end else if (cnt_r == 3'h1) begin
					cnt_r <= 3'h0;
					state_r <= ST_IDLE;
				end else
					cnt_r <= cnt_r - 3'h1;
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule // cpu_alu_flow
`default_nettype wire

// >>> testbench/ahb_master_model.sv
// ahb-lite master model for the alu block register bus
// assumes one slave whose hreadyout comes back as hready
`default_nettype none
module ahb_master_model (
	input wire logic mclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		hsel = 1'h0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
	end
	// one word transfer, each phase held until hready
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= 32'(a);
		do @(posedge mclk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= w ? d : ~hwdata;
		do @(posedge mclk); while (hready !== 1'h1);
		q = hrdata;
		hwdata <= ~d;
		haddr <= ~haddr;
	endtask
endmodule // ahb_master_model
`default_nettype wire

// >>> testbench/cpu_alu_flow_checker.sv
// assertions on the alu block ports
// assumes hready is fed from hreadyout
`default_nettype none
module cpu_alu_flow_checker #(
	parameter SP_W = 3
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic cmdSeen_r;
	logic twoWord_r;
	logic [5:0] opc_r;
	wire logic take = hsel & hready & htrans[1];
	wire logic one = opc_r < 6'h12 && opc_r != 6'h02 && opc_r != 6'h07
		|| opc_r inside {[6'h21:6'h23]} || opc_r > 6'h27;
	wire logic skip = opc_r inside {6'h20, [6'h24:6'h27]};
	always @(posedge mclk) begin
		cmdSeen_r <= !reset && take && hwrite && haddr[7:2] == 6'h00;
		if (cmdSeen_r) begin
			opc_r <= hwdata[5:0];
			twoWord_r <= hwdata[12];
		end
	end
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (reset);
	alu_one_cycle_a:
		assert property ($rose(busy) && one |=> !busy)
		else $error("one cycle op overran");
	word_two_cycle_a:
		assert property ($rose(busy) && opc_r inside {6'h02, 6'h07}
			|=> busy ##1 !busy) else $error("word op length");
	mult_two_cycle_a:
		assert property ($rose(busy) && opc_r inside {[6'h12:6'h17]}
			|-> busy[*2] ##1 !busy) else $error("multiply length");
	short_jump_a:
		assert property ($rose(busy) && opc_r inside {6'h18, 6'h19}
			|-> busy[*2] ##1 !busy) else $error("short jump length");
	abs_jump_a:
		assert property ($rose(busy) && opc_r == 6'h1A
			|-> busy[*3] ##1 !busy) else $error("abs jump length");
	short_call_a:
		assert property ($rose(busy) && opc_r inside {6'h1B, 6'h1C}
			|-> busy[*3] ##1 !busy) else $error("short call length");
	long_call_ret_a:
		assert property ($rose(busy) && opc_r inside {[6'h1D:6'h1F]}
			|-> busy[*4] ##1 !busy) else $error("call or return length");
	skip_bound_a:
		assert property ($rose(busy) && skip |-> ##[1:3] !busy)
		else $error("skip length");
	skip_one_word_a:
		assert property ($rose(busy) && skip && !twoWord_r |-> ##[1:2] !busy)
		else $error("skip over one word too long");
	read_wait_a:
		assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state");
	write_nowait_a:
		assert property (take && hwrite |=> hreadyout)
		else $error("write wait state");
	okay_resp_a:
		assert property (hresp == 1'h0) else $error("response not okay");
	cover property ($rose(busy) && one);
	cover property ($rose(busy) && opc_r == 6'h1D);
	cover property ($rose(busy) && skip && twoWord_r ##3 !busy);
endmodule // cpu_alu_flow_checker
bind cpu_alu_flow cpu_alu_flow_checker #(.SP_W(SP_W)) i_chk (.mclk, .reset,
	.hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata,
	.hreadyout, .hresp, .busy);
`default_nettype wire

// >>> testbench/cpu_alu_and_flow_control_tb.sv
// self-checking bench for the alu and flow control block
// assumes master model and checker are compiled first
`default_nettype none
`include "cpu_alu_consts.vh"
module cpu_alu_and_flow_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, reset, hsel, hwrite, hreadyout, hresp, busy, sk, tw;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize, b;
	logic [5:0] op;
	logic [7:0] d, r, s;
	logic [15:0] p, k, zp, w, e;
	logic [23:0] ew;
	int miscompares, total_checks, n;
	cpu_alu_flow #(.SP_W(3)) i_dut (.mclk(mclk), .reset(reset), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .busy(busy));
	ahb_master_model i_bus (.mclk(mclk), .hready(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata));
	initial begin
		mclk = 1'h0;
		forever #25 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		i_bus.xfer(1'h1, a, v, q);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] x);
		i_bus.xfer(1'h0, a, 32'h0000_0000, q);
		chk(q, x);
	endtask
	task automatic load(input logic [7:0] a, input logic [31:0] v);
		wr(`OFS_SREG, 32'(s));
		wr(a, v);
		wr(`OFS_OPR, 32'(r));
	endtask
	// issue a command and count its busy cycles
	task automatic run(input logic [31:0] c);
		wr(`OFS_CMD, c);
		#1;
		n = 0;
		while (busy === 1'h1) begin
			n++;
			@(posedge mclk);
			#1;
		end
	endtask
	function automatic logic [15:0] ref8(input logic [5:0] o,
		input logic [7:0] a, input logic [7:0] x, input logic [7:0] g);
		logic [8:0] t;
		logic [7:0] h, v;
		logic ci, sb;
		ci = g[`SF_C] && o inside {6'h01, 6'h05, 6'h06, 6'h22};
		sb = o > 6'h02;
		if (sb) t = {1'h0, a} - {1'h0, x} - 9'(ci);
		else t = {1'h0, a} + {1'h0, x} + 9'(ci);
		h = sb ? ~a & x | x & t[7:0] | t[7:0] & ~a
			: a & x | x & ~t[7:0] | ~t[7:0] & a;
		v = sb ? a & ~x & ~t[7:0] | ~a & x & t[7:0]
			: a & x & ~t[7:0] | ~a & ~x & t[7:0];
		case (o)
			6'h08, 6'h09: t[7:0] = a & x;
			6'h0A, 6'h0B, 6'h0D: t[7:0] = a | x;
			6'h0C: t[7:0] = a ^ x;
			6'h0E: t[7:0] = a & ~x;
			6'h0F: t[7:0] = a;
			6'h10: t[7:0] = 8'h00;
			6'h11: return {g, 8'hFF};
			default: begin
				g[`SF_C] = t[8];
				g[`SF_H] = h[3];
			end
		endcase
		g[`SF_V] = o > 6'h07 && o < 6'h11 ? 1'h0 : v[7];
		g[`SF_N] = t[7];
		g[`SF_Z] = t[7:0] == 8'h00
			&& (g[`SF_Z] || !(o inside {6'h05, 6'h06, 6'h22}));
		return {g, o > 6'h20 ? a : t[7:0]};
	endfunction
	function automatic logic [23:0] refw(input logic sb,
		input logic [15:0] x, input logic [7:0] c, input logic [7:0] g);
		logic [16:0] t;
		t = sb ? {1'h0, x} - 17'(c) : {1'h0, x} + 17'(c);
		g[`SF_C] = t[16];
		g[`SF_Z] = t[15:0] == 16'h0000;
		g[`SF_N] = t[15];
		g[`SF_V] = sb ? x[15] & ~t[15] : ~x[15] & t[15];
		g[`SF_S] = g[`SF_N] ^ g[`SF_V];
		return {g, t[15:0]};
	endfunction
	function automatic logic [17:0] refm(input logic [5:0] o,
		input logic [7:0] a, input logic [7:0] x);
		logic signed [16:0] sa, sx;
		logic [15:0] pr;
		sa = {{9{a[7] & o != 6'h12 && o != 6'h15}}, a};
		sx = {{9{x[7] & (o == 6'h13 || o == 6'h16)}}, x};
		pr = 16'(sa * sx);
		if (o > 6'h14) return {pr[15], pr[14:0] == 15'h0000, pr[14:0], 1'h0};
		return {pr[15], pr == 16'h0000, pr};
	endfunction
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#2_000_000;
		miscompares++;
		final_report();
	end
	initial begin
		miscompares = 0;
		total_checks = 0;
		reset = 1'h1;
		void'($urandom(32'h9249_8625));
		repeat (5) @(posedge mclk);
		reset <= 1'h0;
		rchk(`OFS_PC, 32'h0000_0000);
		rchk(`OFS_SREG, 32'h0000_0000);
		rchk(8'h3C, 32'h0000_0000);
		wr(`OFS_PROD, 32'h0000_FFFF);
		rchk(`OFS_PROD, 32'h0000_0000);
		for (int i = 0; i < 36; i++) begin
			if (i inside {2, 7, [18:32]}) continue;
			for (int j = 0; j < 3; j++) begin
				op = 6'(i);
				d = j == 0 ? 8'h7F : 8'($urandom);
				r = j == 0 ? 8'h01 : 8'($urandom);
				s = 8'($urandom);
				load(`OFS_OPD, 32'(d));
				run(32'(op));
				e = ref8(op, d, r, s);
				rchk(`OFS_OPD, 32'(e[7:0]));
				rchk(`OFS_SREG, 32'(e[15:8]));
			end
		end
		for (int i = 0; i < 8; i++) begin
			op = i % 2 ? 6'h07 : 6'h02;
			w = i == 0 ? 16'hFFFF : i == 1 ? 16'h0000 : 16'($urandom);
			r = i < 2 ? 8'h01 : 8'($urandom);
			s = 8'($urandom);
			load(`OFS_WORD, 32'(w));
			run(32'(op));
			ew = refw(op[0], w, r, s);
			rchk(`OFS_WORD, 32'(ew[15:0]));
			rchk(`OFS_SREG, 32'(ew[23:16]));
		end
		for (int i = 0; i < 12; i++) begin
			op = 6'(6'h12 + i % 6);
			d = i < 6 ? 8'h80 : 8'($urandom);
			r = i < 6 ? 8'h80 : 8'($urandom);
			s = 8'($urandom);
			load(`OFS_OPD, 32'(d));
			run(32'(op));
			{s[`SF_C], s[`SF_Z], e} = refm(op, d, r);
			rchk(`OFS_PROD, 32'(e));
			rchk(`OFS_SREG, 32'(s));
		end
		for (int i = 24; i < 30; i++) begin
			op = 6'(i);
			p = 16'($urandom);
			k = 16'($urandom);
			zp = 16'($urandom);
			wr(`OFS_PC, 32'(p));
			wr(`OFS_KARG, 32'(k));
			wr(`OFS_ZPTR, 32'(zp));
			run(32'(op));
			chk(32'(n), op < 6'h1A ? 2 : op == 6'h1D ? 4 : 3);
			e = op inside {6'h18, 6'h1B} ? p + k + 16'h0001
				: op inside {6'h19, 6'h1C} ? zp : k;
			rchk(`OFS_PC, 32'(e));
			if (op > 6'h1A) begin
				run(op == 6'h1C ? 32'h0000_001F : 32'h0000_001E);
				e = p + (op == 6'h1D ? 16'h0002 : 16'h0001);
				rchk(`OFS_PC, 32'(e));
				i_bus.xfer(1'h0, `OFS_SREG, 32'h0000_0000, q);
				if (op == 6'h1C) chk(32'(q[`SF_I]), 1);
			end
		end
		wr(`OFS_CMD, 32'h0000_001D);
		wr(`OFS_CMD, 32'h0000_0018);
		rchk(`OFS_PC, 32'(k));
		for (int i = 0; i < 40; i++) begin
			op = i % 5 == 0 ? 6'h20 : 6'(6'h23 + i % 5);
			d = 8'($urandom);
			r = op == 6'h20 && i % 2 == 1 ? 8'($urandom) : d;
			b = 3'($urandom);
			tw = 1'($urandom);
			p = 16'($urandom);
			s = 8'($urandom);
			sk = op == 6'h20 ? d == r : d[b] == op[0];
			wr(`OFS_PC, 32'(p));
			load(`OFS_OPD, 32'(d));
			run({19'h0_0000, tw, 1'h0, b, 2'h0, op});
			chk(32'(n), sk ? (tw ? 3 : 2) : 1);
			e = p + (sk ? (tw ? 16'h0003 : 16'h0002) : 16'h0001);
			rchk(`OFS_PC, 32'(e));
			rchk(`OFS_SREG, 32'(s));
			rchk(`OFS_STAT, {23'h00_0000, 1'h1, 6'h00, sk, 1'h0});
		end
		final_report();
	end
endmodule // cpu_alu_and_flow_control_tb
`default_nettype wire
